// ---- pkg/dccu_defs.vh ----
// Purpose: Constants for the dual capture/compare unit
// Assumes: Plain register port, byte wide registers
// Notes:   Offsets of value bytes and flag register are local choices
`ifndef DCCU_DEFS_VH
`define DCCU_DEFS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define DCCU_ADDR_W        8
`define DCCU_OFS_U1_CTRL   8'h17
`define DCCU_OFS_U2_CTRL   8'h1d
`define DCCU_OFS_U1_LOW    8'h15
`define DCCU_OFS_U1_HIGH   8'h16
`define DCCU_OFS_U2_LOW    8'h1b
`define DCCU_OFS_U2_HIGH   8'h1c
`define DCCU_OFS_FLAGS     8'h20

// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define DCCU_CTRL_MASK     8'h3f
`define DCCU_MODE_HI       3
`define DCCU_MODE_LO       0
`define DCCU_DUTY_HI       5
`define DCCU_DUTY_LO       4

// ------------------------------------------------------------
// Mode codes
// ------------------------------------------------------------
`define DCCU_M_OFF         4'h0
`define DCCU_M_CAP_FALL    4'h4
`define DCCU_M_CAP_RISE    4'h5
`define DCCU_M_CAP_RISE4   4'h6
`define DCCU_M_CAP_RISE16  4'h7
`define DCCU_M_CMP_SET     4'h8
`define DCCU_M_CMP_CLR     4'h9
`define DCCU_M_CMP_SOFT    4'ha
`define DCCU_M_CMP_TRIG    4'hb
`define DCCU_PRE4_LAST     4'h3
`define DCCU_PRE16_LAST    4'hf

`endif

// ---- src/dccu_top.v ----
// Purpose: Two capture/compare/PWM units behind a byte register port
// Assumes: Wide and period timers live outside; values sync to CLK_IN
// Notes:   Unit 2 trigger also requests a conversion when enabled
`include "dccu_defs.vh"

// Overview of operation
// - Both units identical except trigger effect
// - Value register is two byte registers
// - Code 1011 flags, resets timer, unit2 starts conversion
// - Capture/compare use wide timer, PWM period timer
// - Both PWMs share the period timer
// - Control bits 5:4 hold duty low bits
// - Code 0000 disables and resets unit
// - Mode in bits 3:0, 11xx is PWM
// - Capture codes pick edge and prescale
// - Codes 1000/1001 set/clear pin, flag
// - Code 1010 flags only
// - Capture copies wide timer into value
// - Capture sets flag until software clears
// - New capture overwrites unread value
// - Port write on output pin captures
// - Mode change may set flag falsely
// - Prescaler cleared when off or not capture
// - Prescaler switch keeps counter
// - Compare continuously, action and flag together
// - Zero control forces output latch low
// - Trigger reset never sets overflow flag
module dccu_top
(
    input  wire        CLK_IN,          // 250 MHz clock
    input  wire        RST_IN,          // Sync reset, high
    input  wire [7:0]  ADDR_IN,         // Register address
    input  wire [7:0]  WDATA_IN,        // Write data
    input  wire        WR_IN,           // Write strobe
    input  wire        RD_IN,           // Read strobe
    output reg  [7:0]  RDATA_OUT,       // Read data, next cycle
    input  wire [15:0] WIDE_TIMER_IN,   // Wide timer value
    input  wire [7:0]  PERIOD_TIMER_IN, // Period timer value
    input  wire [1:0]  PERIOD_SUB_IN,   // Period timer sub count
    input  wire        PERIOD_WRAP_IN,  // Period timer matched period
    input  wire        ADC_ENABLE_IN,   // Converter enabled
    input  wire [1:0]  PORT_LATCH_IN,   // Port data latch, per unit
    input  wire [1:0]  PORT_DIR_IN,     // Port direction, 1 = input
    input  wire [1:0]  PIN_IN,          // Unit pin levels
    output wire [1:0]  PIN_OUT,         // Unit pin drive levels
    output wire [1:0]  PIN_OE_OUT,      // Unit pin drive enables
    output reg         WIDE_RESET_OUT,  // Clear wide timer, no overflow
    output reg         ADC_START_OUT,   // Start a conversion
    output reg  [1:0]  FLAG_OUT         // Unit flags
);

    reg  [7:0] ctrl [0:1];
    reg  [1:0] pin_s1;
    reg  [1:0] pin_s2;
    wire [7:0] low_v   [0:1];
    wire [7:0] high_v  [0:1];
    wire [1:0] latch_v;
    wire [1:0] set_v;
    wire [1:0] trig_v;
    wire [1:0] pwm_v;
    wire [1:0] drive_v;
    wire [1:0] eff_pin;
    wire       wr_c1 = WR_IN && (ADDR_IN == `DCCU_OFS_U1_CTRL);
    wire       wr_c2 = WR_IN && (ADDR_IN == `DCCU_OFS_U2_CTRL);

    // ------------------------------------------------------------
    // Pin synchroniser; output pin level is looped back
    // ------------------------------------------------------------
    always @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            pin_s1 <= 2'b00;
            pin_s2 <= 2'b00;
        end
        else
        begin
            pin_s1 <= PIN_IN;
            pin_s2 <= pin_s1;
        end
    end

    // Output pin reflects port latch, so a port write edges the capture input
    assign eff_pin    = pin_s2;
    assign PIN_OE_OUT = ~PORT_DIR_IN;
    assign PIN_OUT    = {drive_v[1] ? latch_v[1] : PORT_LATCH_IN[1],
                         drive_v[0] ? latch_v[0] : PORT_LATCH_IN[0]};

    // ------------------------------------------------------------
    // Units
    // ------------------------------------------------------------
    dccu_unit u_unit1
    (
        .clk_in         (CLK_IN),
        .rst_in         (RST_IN),
        .ctrl_in        (ctrl[0]),
        .ctrl_wr_in     (wr_c1),
        .low_wr_in      (WR_IN && ADDR_IN == `DCCU_OFS_U1_LOW),
        .high_wr_in     (WR_IN && ADDR_IN == `DCCU_OFS_U1_HIGH),
        .wdata_in       (WDATA_IN),
        .wide_in        (WIDE_TIMER_IN),
        .period_in      (PERIOD_TIMER_IN),
        .period_sub_in  (PERIOD_SUB_IN),
        .period_wrap_in (PERIOD_WRAP_IN),
        .pin_in         (eff_pin[0]),
        .low_out        (low_v[0]),
        .high_out       (high_v[0]),
        .out_latch_out  (latch_v[0]),
        .flag_set_out   (set_v[0]),
        .trig_out       (trig_v[0]),
        .pwm_mode_out   (pwm_v[0]),
        .drive_out      (drive_v[0])
    );

    dccu_unit u_unit2
    (
        .clk_in         (CLK_IN),
        .rst_in         (RST_IN),
        .ctrl_in        (ctrl[1]),
        .ctrl_wr_in     (wr_c2),
        .low_wr_in      (WR_IN && ADDR_IN == `DCCU_OFS_U2_LOW),
        .high_wr_in     (WR_IN && ADDR_IN == `DCCU_OFS_U2_HIGH),
        .wdata_in       (WDATA_IN),
        .wide_in        (WIDE_TIMER_IN),
        .period_in      (PERIOD_TIMER_IN),
        .period_sub_in  (PERIOD_SUB_IN),
        .period_wrap_in (PERIOD_WRAP_IN),
        .pin_in         (eff_pin[1]),
        .low_out        (low_v[1]),
        .high_out       (high_v[1]),
        .out_latch_out  (latch_v[1]),
        .flag_set_out   (set_v[1]),
        .trig_out       (trig_v[1]),
        .pwm_mode_out   (pwm_v[1]),
        .drive_out      (drive_v[1])
    );

    // ------------------------------------------------------------
    // Registers, flags and trigger outputs
    // ------------------------------------------------------------
    always @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            ctrl[0]        <= 8'h00;
            ctrl[1]        <= 8'h00;
            FLAG_OUT       <= 2'b00;
            WIDE_RESET_OUT <= 1'b0;
            ADC_START_OUT  <= 1'b0;
            RDATA_OUT      <= 8'h00;
        end
        else
        begin
            if (wr_c1)
                ctrl[0] <= WDATA_IN & `DCCU_CTRL_MASK;
            if (wr_c2)
                ctrl[1] <= WDATA_IN & `DCCU_CTRL_MASK;
            // Set wins over a software clear in the same cycle
            if (WR_IN && ADDR_IN == `DCCU_OFS_FLAGS)
                FLAG_OUT <= (FLAG_OUT & ~WDATA_IN[1:0]) | set_v;
            else
                FLAG_OUT <= FLAG_OUT | set_v;
            WIDE_RESET_OUT <= trig_v[0] | trig_v[1];
            ADC_START_OUT  <= trig_v[1] & ADC_ENABLE_IN;
            RDATA_OUT      <= 8'h00;
            if (RD_IN)
            begin
                case (ADDR_IN)
                    `DCCU_OFS_U1_CTRL: RDATA_OUT <= ctrl[0];
                    `DCCU_OFS_U2_CTRL: RDATA_OUT <= ctrl[1];
                    `DCCU_OFS_U1_LOW:  RDATA_OUT <= low_v[0];
                    `DCCU_OFS_U1_HIGH: RDATA_OUT <= high_v[0];
                    `DCCU_OFS_U2_LOW:  RDATA_OUT <= low_v[1];
                    `DCCU_OFS_U2_HIGH: RDATA_OUT <= high_v[1];
                    `DCCU_OFS_FLAGS:   RDATA_OUT <= {6'h00, FLAG_OUT};
                    default:           RDATA_OUT <= 8'h00;
                endcase
            end
        end
    end

endmodule // dccu_top

// ---- src/dccu_unit.v ----
// Purpose: One capture/compare/PWM unit
// Assumes: Timers and pin level synchronous to CLK_IN
// Notes:   Trigger output is one cycle; top decides its effect
`include "dccu_defs.vh"

module dccu_unit
(
    input  wire        clk_in,        // System clock
    input  wire        rst_in,        // Sync reset
    input  wire [7:0]  ctrl_in,       // Control register
    input  wire        ctrl_wr_in,    // Control written this cycle
    input  wire        low_wr_in,     // Low byte write
    input  wire        high_wr_in,    // High byte write
    input  wire [7:0]  wdata_in,      // Write data
    input  wire [15:0] wide_in,       // Wide timer value
    input  wire [7:0]  period_in,     // Period timer value
    input  wire [1:0]  period_sub_in, // Period timer sub count
    input  wire        period_wrap_in,// Period timer wraps
    input  wire        pin_in,        // Synchronised pin level
    output reg  [7:0]  low_out,       // Value low byte
    output reg  [7:0]  high_out,      // Value high byte
    output reg         out_latch_out, // Compare/PWM output latch
    output wire        flag_set_out,  // Flag set pulse
    output wire        trig_out,      // Special event pulse
    output wire        pwm_mode_out,  // Unit in PWM
    output wire        drive_out      // Unit drives the pin
);

    wire [3:0] mode = ctrl_in[`DCCU_MODE_HI:`DCCU_MODE_LO];
    wire [1:0] duty_lsb = ctrl_in[`DCCU_DUTY_HI:`DCCU_DUTY_LO];
    wire cap_mode = (mode[3:2] == 2'b01);
    wire cmp_mode = (mode[3:2] == 2'b10);
    wire pwm_mode = (mode[3:2] == 2'b11);

    reg        pin_q;
    reg [3:0]  pre_cnt;
    reg [1:0]  duty_lsb_q;
    reg        match_q;

    // ------------------------------------------------------------
    // Edge detect and prescaler
    // ------------------------------------------------------------
    wire rise = pin_in & ~pin_q;
    wire fall = ~pin_in & pin_q;
    wire [3:0] pre_last = (mode == `DCCU_M_CAP_RISE4) ? `DCCU_PRE4_LAST
                                                      : `DCCU_PRE16_LAST;
    wire pre_hit = rise && (pre_cnt == pre_last);
    reg  capture;
    always @*
    begin
        case (mode)
            `DCCU_M_CAP_FALL:   capture = fall;
            `DCCU_M_CAP_RISE:   capture = rise;
            `DCCU_M_CAP_RISE4:  capture = pre_hit;
            `DCCU_M_CAP_RISE16: capture = pre_hit;
            default:            capture = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Compare and PWM
    // ------------------------------------------------------------
    wire match = cmp_mode && ({high_out, low_out} == wide_in);
    wire match_edge = match && !match_q;
    wire pwm_clear = ({high_out, duty_lsb_q} == {period_in, period_sub_in});

    assign flag_set_out = capture | match_edge;
    assign trig_out     = match_edge && (mode == `DCCU_M_CMP_TRIG);
    assign pwm_mode_out = pwm_mode;
    assign drive_out    = cmp_mode | pwm_mode;

    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pin_q         <= 1'b0;
            pre_cnt       <= 4'h0;
            duty_lsb_q    <= 2'h0;
            match_q       <= 1'b0;
            low_out       <= 8'h00;
            high_out      <= 8'h00;
            out_latch_out <= 1'b0;
        end
        else
        begin
            pin_q   <= pin_in;
            match_q <= match;
            if (!cap_mode || (ctrl_wr_in && mode == `DCCU_M_OFF))
                pre_cnt <= 4'h0;
            else if (rise)
                pre_cnt <= pre_hit ? 4'h0 : pre_cnt + 4'h1;
            if (capture)
            begin
                low_out  <= wide_in[7:0];
                high_out <= wide_in[15:8];
            end
            else
            begin
                if (low_wr_in)
                    low_out <= wdata_in;
                if (high_wr_in && !pwm_mode)
                    high_out <= wdata_in;
                if (pwm_mode && period_wrap_in)
                begin
                    high_out   <= low_out;
                    duty_lsb_q <= duty_lsb;
                end
            end
            if (mode == `DCCU_M_OFF)
                out_latch_out <= 1'b0;
            else if (match_edge && mode == `DCCU_M_CMP_SET)
                out_latch_out <= 1'b1;
            else if (match_edge && mode == `DCCU_M_CMP_CLR)
                out_latch_out <= 1'b0;
            else if (pwm_mode && period_wrap_in)
                out_latch_out <= (low_out != 8'h00) || (duty_lsb != 2'h0);
            else if (pwm_mode && pwm_clear)
                out_latch_out <= 1'b0;
        end
    end

endmodule // dccu_unit

// ---- testbench/dccu_chk_asserts.sv ----
// Purpose: Port assertions for the dual capture/compare unit
// Assumes: Bound to dccu_top, one clock domain
// Notes:   Control shadows follow bus writes
module dccu_chk
(
    input wire       CLK_IN,         // Clock
    input wire       RST_IN,         // Sync reset
    input wire [7:0] ADDR_IN,        // Address
    input wire [7:0] WDATA_IN,       // Write data
    input wire       WR_IN,          // Write strobe
    input wire       RD_IN,          // Read strobe
    input wire [7:0] RDATA_OUT,      // Read data
    input wire [1:0] PORT_LATCH_IN,  // Port latch
    input wire [1:0] PIN_IN,         // Pin level
    input wire [1:0] PIN_OUT,        // Pin drive
    input wire       WIDE_RESET_OUT, // Timer clear
    input wire       ADC_START_OUT,  // Conversion start
    input wire       ADC_ENABLE_IN,  // Converter enabled
    input wire [1:0] FLAG_OUT        // Unit flags
);
    reg  [7:0] c1;
    reg  [7:0] c2;
    wire       clr1 = WR_IN && ADDR_IN == 8'h20 && WDATA_IN[0];
    wire       clr2 = WR_IN && ADDR_IN == 8'h20 && WDATA_IN[1];
    // ------------------------------------------------------------
    // Control shadows
    // ------------------------------------------------------------
    always @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            c1 <= 8'h00;
            c2 <= 8'h00;
        end
        else if (WR_IN && ADDR_IN == 8'h17)
            c1 <= WDATA_IN;
        else if (WR_IN && ADDR_IN == 8'h1d)
            c2 <= WDATA_IN;
    end
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    property p_ctrl_rd; RD_IN && ADDR_IN == 8'h17 |=> RDATA_OUT == (c1 & 8'h3f); endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
    property p_off; c1[3:0] == 4'h0 |-> PIN_OUT[0] == PORT_LATCH_IN[0]; endproperty
    a_off: assert property (p_off) else $error("disabled unit drives pin");
    property p_set; $rose(FLAG_OUT[0]) && c1[3:0] == 4'h8 |-> PIN_OUT[0]; endproperty
    a_set: assert property (p_set) else $error("set on match missing");
    property p_clr; $rose(FLAG_OUT[0]) && c1[3:0] == 4'h9 |-> !PIN_OUT[0]; endproperty
    a_clr: assert property (p_clr) else $error("clear on match missing");
    property p_rise; $rose(FLAG_OUT[0]) && c1[3:0] == 4'h5 |-> $past(PIN_IN[0], 3); endproperty
    a_rise: assert property (p_rise) else $error("capture without rising edge");
    property p_fall; $rose(FLAG_OUT[0]) && c1[3:0] == 4'h4 |-> !$past(PIN_IN[0], 3); endproperty
    a_fall: assert property (p_fall) else $error("capture without falling edge");
    property p_hold1; FLAG_OUT[0] && !clr1 |=> FLAG_OUT[0]; endproperty
    a_hold1: assert property (p_hold1) else $error("unit 1 flag dropped");
    property p_hold2; FLAG_OUT[1] && !clr2 |=> FLAG_OUT[1]; endproperty
    a_hold2: assert property (p_hold2) else $error("unit 2 flag dropped");
    property p_trig; WIDE_RESET_OUT |-> $past(c1[3:0]) == 4'hb || $past(c2[3:0]) == 4'hb; endproperty
    a_trig: assert property (p_trig) else $error("timer clear outside trigger mode");
    property p_adc;
        ADC_START_OUT |-> WIDE_RESET_OUT && $past(c2[3:0]) == 4'hb && $past(ADC_ENABLE_IN);
    endproperty
    a_adc: assert property (p_adc) else $error("conversion start wrong");
    c_trig: cover property (WIDE_RESET_OUT && ADC_START_OUT);
    c_flag2: cover property ($rose(FLAG_OUT[1]));
    c_pre16: cover property ($rose(FLAG_OUT[0]) && c1[3:0] == 4'h7);
    c_pwm: cover property (c1[3:2] == 2'b11 && PIN_OUT[0]);
endmodule // dccu_chk

bind dccu_top dccu_chk chk_u (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
    .PORT_LATCH_IN(PORT_LATCH_IN), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
    .WIDE_RESET_OUT(WIDE_RESET_OUT), .ADC_START_OUT(ADC_START_OUT),
    .ADC_ENABLE_IN(ADC_ENABLE_IN), .FLAG_OUT(FLAG_OUT));

// ---- testbench/dccu_pin_model.sv ----
// Purpose: Signal source and load on the two unit pins
// Assumes: Source level is set by the bench at clock edges
// Notes:   Unit drive wins while its enable is high
module dccu_pin_model
(
    input  wire [1:0] src_in,  // Source level
    input  wire [1:0] out_in,  // Unit drive level
    input  wire [1:0] oe_in,   // Unit drive enable
    output wire [1:0] pin_out  // Resolved pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Output pin reads back its own drive, so a port write can capture
    assign pin_out = (oe_in & out_in) | (~oe_in & src_in);
endmodule // dccu_pin_model

// ---- testbench/dccu_top_tb.sv ----
// Purpose: Self-checking bench for the dual capture/compare unit
// Assumes: Timers are modelled here; pin source is the partner
// Notes:   Timer stands still during captures so values are known
module dccu_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, wr, rd, run, adce;
    logic [7:0]  addr, wd, d;
    logic [15:0] wt, v;
    logic [31:0] seed, r;
    logic [9:0]  pc;
    logic [1:0]  lat, dir, src;
    wire  [7:0]  rdata;
    wire  [1:0]  pin, pout, poe, flag;
    wire         wres, adcs;
    int          fail_count, cmp_count, ntrig, nadc, u, c;
    dccu_top dut_u (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wd), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .WIDE_TIMER_IN(wt), .PERIOD_TIMER_IN(pc[9:2]),
        .PERIOD_SUB_IN(pc[1:0]), .PERIOD_WRAP_IN(pc == 10'h3ff), .ADC_ENABLE_IN(adce),
        .PORT_LATCH_IN(lat), .PORT_DIR_IN(dir), .PIN_IN(pin), .PIN_OUT(pout),
        .PIN_OE_OUT(poe), .WIDE_RESET_OUT(wres), .ADC_START_OUT(adcs), .FLAG_OUT(flag));
    dccu_pin_model pm_u (.src_in(src), .out_in(pout), .oe_in(poe), .pin_out(pin));
    // ------------------------------------------------------------
    // Clock, timers and helpers
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        pc <= pc + 10'h001;
        if (wres) ntrig <= ntrig + 1;
        if (adcs) nadc <= nadc + 1;
        if (wres) wt <= 16'h0000;
        else if (run) wt <= wt + 16'h0001;
    end
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task print_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(string s, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task wreg(logic [7:0] a, logic [7:0] x);
        wr <= 1'b1; addr <= a; wd <= x;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task rchk(logic [7:0] a, logic [7:0] e);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
        chk("read data", e, d);
    endtask
    task wflag(int k);
        int i;
        for (i = 0; i < 300 && flag[k] !== 1'b1; i++) @(posedge clk);
        chk("flag", 1, flag[k]);
        if (i == 300) print_verdict();
    endtask
    task pulses(int k, int n);
        repeat (n)
        begin
            src[k] <= 1'b1;
            repeat (6) @(posedge clk);
            src[k] <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask
    task capt(int k, logic [3:0] m);
        logic [7:0] ca;
        int n;
        ca = k ? 8'h1d : 8'h17;
        n = m == 4'h6 ? 4 : m == 4'h7 ? 16 : 1;
        wreg(ca, 8'h00);
        wreg(ca, {4'h0, m});
        pulses(k, n - 1);
        wreg(ca, 8'h00);
        wreg(ca, {4'h0, m});
        wreg(8'h20, 8'h03);
        r = rnd();
        wt <= r[15:0];
        pulses(k, n - 1);
        chk("early flag", 0, flag[k]);
        pulses(k, 1);
        wflag(k);
        chk("other flag", 0, flag[1 - k]);
        r = rnd();
        wt <= r[15:0];
        pulses(k, n);
        rchk(ca - 8'h02, r[7:0]);
        rchk(ca - 8'h01, r[15:8]);
    endtask
    task cmpstep(int k, logic [3:0] m, logic e);
        run <= 1'b0;
        wreg(k ? 8'h1d : 8'h17, {4'h0, m});
        wreg(8'h20, 8'h03);
        wt <= v - 16'h0014;
        run <= 1'b1;
        wflag(k);
        chk("pin", e, pout[k]);
    endtask
    task waitpc(logic [9:0] t);
        int i;
        for (i = 0; i < 1100 && pc !== t; i++) @(posedge clk);
        if (i == 1100)
        begin
            fail_count++;
            print_verdict();
        end
    endtask
    task pwmchk();
        logic [7:0] l;
        logic [9:0] t;
        run <= 1'b0;
        r = rnd();
        l = {1'b0, r[6:0]} | 8'h10;
        t = {l, r[9:8]};
        wreg(8'h15, l);
        wreg(8'h1b, l);
        wreg(8'h17, {2'b00, r[9:8], 4'hc});
        wreg(8'h1d, {2'b00, r[9:8], 4'hf});
        wreg(8'h16, ~l);
        waitpc(10'h3ff);
        waitpc(t >> 1);
        chk("pwm set", 16'h0003, pout);
        waitpc(t + 10'h004);
        chk("pwm cleared", 16'h0000, pout);
        rchk(8'h16, l);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 32'h8eab9d3b;
        {rst, wr, rd, run} = 4'b1000;
        adce = 1'b1;
        {addr, wd, wt, pc} = 42'h0;
        {lat, dir, src} = 6'b001100;
        {fail_count, cmp_count, ntrig, nadc} = 128'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rchk(8'h1d, 8'h00);
        rchk(8'h20, 8'h00);
        rchk(8'h40, 8'h00);
        wreg(8'h17, 8'hff);
        rchk(8'h17, 8'h3f);
        for (u = 0; u < 2; u++)
            for (c = 4; c < 8; c++)
                capt(u, c[3:0]);
        wreg(8'h17, 8'h00);
        wreg(8'h17, 8'h05);
        dir <= 2'b10;
        wreg(8'h20, 8'h03);
        r = rnd();
        wt <= r[15:0];
        lat <= 2'b01;
        wflag(0);
        rchk(8'h15, r[7:0]);
        dir <= 2'b11;
        lat <= 2'b00;
        for (u = 0; u < 2; u++)
        begin
            r = rnd();
            v = r[15:0] | 16'h0100;
            wreg(u ? 8'h1d : 8'h17, 8'h00);
            wreg(u ? 8'h1b : 8'h15, v[7:0]);
            wreg(u ? 8'h1c : 8'h16, v[15:8]);
            cmpstep(u, 4'h8, 1'b1);
            cmpstep(u, 4'ha, 1'b1);
            cmpstep(u, 4'h9, 1'b0);
            cmpstep(u, 4'hb, 1'b0);
            cmpstep(u, 4'h8, 1'b1);
            wreg(u ? 8'h1d : 8'h17, 8'h00);
            wreg(u ? 8'h1d : 8'h17, 8'h0a);
            chk("latch", 0, pout[u]);
        end
        adce <= 1'b0;
        cmpstep(1, 4'hb, 1'b0);
        pwmchk();
        chk("timer clears", 3, ntrig);
        chk("conversions", 1, nadc);
        print_verdict();
    end
    initial
    begin
        repeat (50000) @(posedge clk);
        fail_count++;
        print_verdict();
    end
endmodule // dccu_top_tb
